/* src/rtcl_pkg.sv */
// Constants shared by the time latch and interrupt block
package rtcl_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [4:0] ADR_HUND = 5'h00;
    localparam logic [4:0] ADR_TIME_LO = 5'h01;
    localparam logic [4:0] ADR_TIME_HI = 5'h07;
    localparam logic [4:0] ADR_ALM_LO = 5'h08;
    localparam logic [4:0] ADR_ALM_HI = 5'h0f;
    localparam logic [4:0] ADR_EVT = 5'h10;
    localparam logic [4:0] ADR_CMD = 5'h11;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int EVT_ALARM_BIT = 0;
    localparam int EVT_PER_LO = 1;
    localparam int EVT_PER_HI = 6;
    localparam int EVT_ANY_BIT = 7;
    localparam int CMD_IEN_BIT = 4;
    localparam int ALM_MASK_BIT = 7;
    // ****************************************
    // Sizes and reset values
    // ****************************************
    localparam int NUM_TIME = 7;
    localparam int NUM_ALM = 8;
    localparam int NUM_PER = 6;
    localparam int BUS_W = 17;
    localparam logic [7:0] EVT_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] CMD_RST = 8'h00;
    localparam logic [7:0] RDAT_RST = 8'h00;
    localparam logic [7:0] HUND_ZERO = 8'h00;
    localparam logic [BUS_W-1:0] BUS_IDLE = 17'h1e000;
endpackage : rtcl_pkg

/* src/rtcl_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module rtcl_sync import rtcl_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pins in, filtered level out
    input wire logic [BUS_W-1:0] pin_in,
    output logic [BUS_W-1:0] level_out
);
    typedef struct packed {
        logic [BUS_W-1:0] s1;
        logic [BUS_W-1:0] s2;
        logic [BUS_W-1:0] s3;
        logic [BUS_W-1:0] acc;
    } rtcl_sync_st_t;

    rtcl_sync_st_t st_r;
    rtcl_sync_st_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = pin_in;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        // Only agreed bits move, a glitch between stages is dropped
        for (int i = 0; i < BUS_W; i++) begin
            if (st_r.s2[i] == st_r.s3[i]) begin
                st_nxt.acc[i] = st_r.s3[i];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= {4{BUS_IDLE}};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign level_out = st_r.acc;
endmodule : rtcl_sync
`default_nettype wire

/* src/rtcl_alarm_ram.sv */
// Alarm storage with registered read port and compare taps
`timescale 1ns/1ns
`default_nettype none
module rtcl_alarm_ram import rtcl_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Write port
    input wire logic wr_en,
    input wire logic [2:0] wr_idx,
    input wire logic [7:0] wr_data,
    // Read port
    input wire logic [2:0] rd_idx,
    output logic [7:0] rd_data,
    // All entries for the comparator
    output logic [NUM_ALM-1:0][7:0] alm_all
);
    typedef struct packed {
        logic [NUM_ALM-1:0][7:0] mem;
        logic [7:0] q;
    } rtcl_ram_st_t;

    rtcl_ram_st_t st_r;
    rtcl_ram_st_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (wr_en) begin
            st_nxt.mem[wr_idx] = wr_data;
        end
        st_nxt.q = st_r.mem[rd_idx];
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rd_data = st_r.q;
    assign alm_all = st_r.mem;
endmodule : rtcl_alarm_ram
`default_nettype wire

/* src/rtcl_top.sv */
// Time snapshot, alarm compare, event flags and interrupt output
// Operation
// - Reading hundredths captures hours through day into the snapshot.
// - Hundredths read returns the live counter, never latched.
// - Time register reads return snapshot, held until next hundredths read.
// - Alarm locations read back directly, no snapshot.
// - Event flags record every counter increment regardless of mask.
// - Event flag register clears right after each read.
// - D7 marks any interrupt; D0 also marks an alarm interrupt.
// - Reading event flags releases the interrupt output.
// - Periodic interrupts need enable D4 and a mask bit D1-D6.
// - Periodic interrupt fires on the next increment of an enabled counter.
// - Alarm interrupts need enable D4 and alarm mask D0.
// - Exact alarm match sets D0, D7 and turns the output on.
// - Alarm fields other than hundredths with their mask bit set match any value.
// - Masked hundredths alarm matches only when hundredths is zero.
// - Mask register written at 10H, where event flags read.
// - Mask value 08H enables only the one-second interrupt.
// - Command register lives at 11H.
`timescale 1ns/1ns
`default_nettype none
module rtcl_top import rtcl_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Processor bus pins
    input wire logic ale,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [4:0] addr,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    // Open-drain interrupt pin
    output logic int_out,
    output logic int_oe,
    // Live counters from the counter chain
    input wire logic [7:0] tm_hund,
    input wire logic [7:0] tm_hour,
    input wire logic [7:0] tm_min,
    input wire logic [7:0] tm_sec,
    input wire logic [7:0] tm_month,
    input wire logic [7:0] tm_date,
    input wire logic [7:0] tm_year,
    input wire logic [7:0] tm_day,
    // Increment pulses: 100Hz, 10Hz, 1s, 1min, 1h, 1day
    input wire logic [NUM_PER-1:0] per_tick,
    // Counter write port to the counter chain
    output logic cnt_wr,
    output logic [2:0] cnt_wsel,
    output logic [7:0] cnt_wdata,
    // Command register contents
    output logic [7:0] cmd_out
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [4:0] addr;
        logic cs;
        logic rd_prev;
        logic wr_prev;
        logic [NUM_TIME-1:0][7:0] snap;
        logic [7:0] evt;
        logic [7:0] mask;
        logic [7:0] cmd;
        logic [7:0] rdat;
        logic oe;
        logic int_on;
        logic tick_d;
        logic cnt_wr;
        logic [2:0] cnt_wsel;
        logic [7:0] cnt_wdata;
    } rtcl_st_t;

    rtcl_st_t st_r;
    rtcl_st_t st_nxt;

    // ****************************************
    // Pin synchronisation
    // ****************************************
    logic [BUS_W-1:0] bus_s;
    logic ale_s;
    logic cs_s;
    logic rd_s;
    logic wr_s;
    logic [4:0] addr_s;
    logic [7:0] din_s;

    rtcl_sync u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .pin_in({ale, cs_n, rd_n, wr_n, addr, data_in}),
        .level_out(bus_s)
    );

    assign ale_s = bus_s[16];
    assign cs_s = ~bus_s[15];
    assign rd_s = ~bus_s[14];
    assign wr_s = ~bus_s[13];
    assign addr_s = bus_s[12:8];
    assign din_s = bus_s[7:0];

    // ****************************************
    // Access decode
    // ****************************************
    logic rd_go;
    logic wr_go;
    logic rd_evt;
    logic alm_wr;
    logic [7:0] alm_q;
    logic [NUM_ALM-1:0][7:0] alm_all;
    logic [NUM_ALM-1:0][7:0] live;
    logic [NUM_ALM-1:0] fld_hit;
    logic alarm_evt;
    logic per_fire;
    logic alm_fire;
    logic fire;
    logic ien;

    // Read acts on the strobe's leading edge, write on its trailing edge
    assign rd_go = st_r.cs && rd_s && !st_r.rd_prev;
    assign wr_go = st_r.cs && !wr_s && st_r.wr_prev;
    assign rd_evt = rd_go && (st_r.addr == ADR_EVT);
    assign alm_wr = wr_go && (st_r.addr >= ADR_ALM_LO) && (st_r.addr <= ADR_ALM_HI);
    assign live = {tm_day, tm_year, tm_date, tm_month, tm_sec, tm_min, tm_hour, tm_hund};
    assign ien = st_r.cmd[CMD_IEN_BIT];

    rtcl_alarm_ram u_alarm (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(alm_wr),
        .wr_idx(st_r.addr[2:0]),
        .wr_data(din_s),
        .rd_idx(st_r.addr[2:0]),
        .rd_data(alm_q),
        .alm_all(alm_all)
    );

    // ****************************************
    // Alarm comparator
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < NUM_ALM; gi++) begin : g_cmp
            if (gi == 0) begin : g_hund
                // Masked hundredths compares against zero
                assign fld_hit[gi] = alm_all[gi][ALM_MASK_BIT] ? (live[gi] == HUND_ZERO) :
                                     (alm_all[gi][6:0] == live[gi][6:0]);
            end else begin : g_field
                assign fld_hit[gi] = alm_all[gi][ALM_MASK_BIT] ||
                                     (alm_all[gi][6:0] == live[gi][6:0]);
            end
        end
    endgenerate

    // Counters settle one cycle after the tick, so compare then
    assign alarm_evt = st_r.tick_d && (&fld_hit);

    // ****************************************
    // Interrupt sources
    // ****************************************
    // Mask bit n+1 gates tick n; 08H thus picks the 1s tick alone
    assign per_fire = ien && |(per_tick & st_r.mask[EVT_PER_HI:EVT_PER_LO]);
    assign alm_fire = ien && st_r.mask[EVT_ALARM_BIT] && alarm_evt;
    assign fire = per_fire || alm_fire;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.rd_prev = rd_s;
        st_nxt.wr_prev = wr_s;
        st_nxt.tick_d = per_tick[0];
        st_nxt.cnt_wr = 1'b0;
        // Address latch is transparent while ALE is high
        if (ale_s) begin
            st_nxt.addr = addr_s;
            st_nxt.cs = cs_s;
        end
        // Read data
        if (rd_go) begin
            st_nxt.oe = 1'b1;
            if (st_r.addr == ADR_HUND) begin
                st_nxt.rdat = tm_hund;
                for (int i = 0; i < NUM_TIME; i++) begin
                    st_nxt.snap[i] = live[i+1];
                end
            end else if (st_r.addr <= ADR_TIME_HI) begin
                st_nxt.rdat = st_r.snap[st_r.addr[2:0] - 3'h1];
            end else if (st_r.addr <= ADR_ALM_HI) begin
                st_nxt.rdat = alm_q;
            end else if (st_r.addr == ADR_EVT) begin
                st_nxt.rdat = st_r.evt;
            end else if (st_r.addr == ADR_CMD) begin
                st_nxt.rdat = st_r.cmd;
            end else begin
                st_nxt.rdat = RDAT_RST;
            end
        end else if (!rd_s || !st_r.cs) begin
            st_nxt.oe = 1'b0;
        end
        // Writes
        if (wr_go) begin
            if (st_r.addr <= ADR_TIME_HI) begin
                st_nxt.cnt_wr = 1'b1;
                st_nxt.cnt_wsel = st_r.addr[2:0];
                st_nxt.cnt_wdata = din_s;
            end else if (st_r.addr == ADR_EVT) begin
                st_nxt.mask = din_s;
            end else if (st_r.addr == ADR_CMD) begin
                st_nxt.cmd = din_s;
            end
        end
        // Flags: clear on read, new events in the same cycle still land
        if (rd_evt) begin
            st_nxt.evt = EVT_RST;
            st_nxt.int_on = 1'b0;
        end
        st_nxt.evt[EVT_PER_HI:EVT_PER_LO] = st_nxt.evt[EVT_PER_HI:EVT_PER_LO] | per_tick;
        if (alm_fire) begin
            st_nxt.evt[EVT_ALARM_BIT] = 1'b1;
        end
        if (fire) begin
            st_nxt.evt[EVT_ANY_BIT] = 1'b1;
            st_nxt.int_on = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.evt <= EVT_RST;
            st_r.mask <= MASK_RST;
            st_r.cmd <= CMD_RST;
            st_r.rdat <= RDAT_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign data_out = st_r.rdat;
    assign data_oe = st_r.oe;
    // N-channel pull-down: low whenever driven
    assign int_out = 1'b0;
    assign int_oe = st_r.int_on;
    assign cnt_wr = st_r.cnt_wr;
    assign cnt_wsel = st_r.cnt_wsel;
    assign cnt_wdata = st_r.cnt_wdata;
    assign cmd_out = st_r.cmd;

    // ****************************************
    // Checks
    // ****************************************
    sequence seq_rd_hund;
        rd_go && (st_r.addr == ADR_HUND);
    endsequence

    sequence seq_rd_time;
        rd_go && (st_r.addr >= ADR_TIME_LO) && (st_r.addr <= ADR_TIME_HI);
    endsequence

    sequence seq_alarm_fire;
        ien && st_r.mask[EVT_ALARM_BIT] && st_r.tick_d && (&fld_hit);
    endsequence

    AST_SNAP_TAKE: assert property (@(posedge clk) disable iff (!rst_n)
        seq_rd_hund |=> (st_r.snap[0] == $past(tm_hour)) && (st_r.snap[6] == $past(tm_day)))
        else $error("snapshot not taken on hundredths read");

    AST_HUND_LIVE: assert property (@(posedge clk) disable iff (!rst_n)
        seq_rd_hund |=> data_out == $past(tm_hund))
        else $error("hundredths read not live");

    AST_SNAP_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        !(rd_go && (st_r.addr == ADR_HUND)) |=> $stable(st_r.snap))
        else $error("snapshot changed without hundredths read");

    AST_TIME_READ: assert property (@(posedge clk) disable iff (!rst_n)
        seq_rd_time |=> data_out == $past(st_r.snap[st_r.addr[2:0] - 3'h1]))
        else $error("time read not from snapshot");

    AST_ALM_READ: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_go && (st_r.addr >= ADR_ALM_LO) && (st_r.addr <= ADR_ALM_HI)) |=> data_out == $past(alm_q))
        else $error("alarm read wrong");

    AST_EVT_RECORD: assert property (@(posedge clk) disable iff (!rst_n)
        (per_tick != '0) |=> (st_r.evt[EVT_PER_HI:EVT_PER_LO] & $past(per_tick)) == $past(per_tick))
        else $error("increment not recorded");

    AST_EVT_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_evt && per_tick == '0 && !fire) |=> st_r.evt == EVT_RST ##1 data_oe)
        else $error("flags not cleared after read");

    AST_INT_RELEASE: assert property (@(posedge clk) disable iff (!rst_n)
        (rd_evt && !fire) |=> !int_oe)
        else $error("interrupt not released by read");

    AST_IEN_GATE: assert property (@(posedge clk) disable iff (!rst_n)
        (!ien && !int_oe && !rd_evt) |=> !int_oe)
        else $error("interrupt without enable");

    AST_ALARM_SET: assert property (@(posedge clk) disable iff (!rst_n)
        seq_alarm_fire |=> st_r.evt[EVT_ALARM_BIT] && st_r.evt[EVT_ANY_BIT] && int_oe)
        else $error("alarm match did not flag");
endmodule : rtcl_top
`default_nettype wire

/* dv/rtcl_cpu_model.sv */
// Processor bus master model for the clock block's bus pins
`timescale 1ns/1ns
`default_nettype none
module rtcl_cpu_model (
    // Clock
    input wire logic clk,
    // Bus pins
    output logic ale,
    output logic cs_n,
    output logic rd_n,
    output logic wr_n,
    output logic [4:0] addr,
    output logic [7:0] data_in,
    input wire logic [7:0] data_out,
    input wire logic data_oe
);
    // ****************************************
    // Idle bus
    // ****************************************
    initial begin
        ale = 1'b1;
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        addr = 5'h1f;
        data_in = 8'h00;
    end
    // ****************************************
    // Bus cycles
    // ****************************************
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    // Strobes last 8 clocks to ride over the pin filter delay
    task automatic bus_wr(input logic [4:0] a, input logic [7:0] d);
        step(1);
        addr = a;
        cs_n = 1'b0;
        data_in = d;
        step(2);
        wr_n = 1'b0;
        step(8);
        wr_n = 1'b1;
        step(6);
        cs_n = 1'b1;
        // Released lines show the inverse so stale values never pass
        addr = ~a;
        data_in = ~d;
        step(2);
    endtask : bus_wr
    task automatic bus_rd(input logic [4:0] a, output logic [7:0] d, output logic oe);
        step(1);
        addr = a;
        cs_n = 1'b0;
        step(2);
        rd_n = 1'b0;
        step(8);
        d = data_out;
        oe = data_oe;
        rd_n = 1'b1;
        step(6);
        cs_n = 1'b1;
        addr = ~a;
        step(2);
    endtask : bus_rd
endmodule : rtcl_cpu_model
`default_nettype wire

/* dv/rtcl_top_tb.sv */
// Self-checking bench for the time latch and interrupt block
`timescale 1ns/1ns
`default_nettype none
module rtcl_top_tb;
    import rtcl_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ale, cs_n, rd_n, wr_n, data_oe, int_out, int_oe, cnt_wr;
    logic [4:0] addr;
    logic [7:0] data_in, data_out, cnt_wdata, cmd_out, cw_dat;
    logic [2:0] cnt_wsel, cw_sel;
    logic [7:0] tm_v [8];
    logic [NUM_PER-1:0] per_tick = 6'h00;
    int errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    int cw_n = 0;
    always #20 clk = ~clk;
    // ****************************************
    // Device and bus master
    // ****************************************
    rtcl_top dut_u (.clk(clk), .rst_n(rst_n), .ale(ale), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
        .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .int_out(int_out),
        .int_oe(int_oe), .tm_hund(tm_v[0]), .tm_hour(tm_v[1]), .tm_min(tm_v[2]), .tm_sec(tm_v[3]),
        .tm_month(tm_v[4]), .tm_date(tm_v[5]), .tm_year(tm_v[6]), .tm_day(tm_v[7]),
        .per_tick(per_tick), .cnt_wr(cnt_wr), .cnt_wsel(cnt_wsel), .cnt_wdata(cnt_wdata),
        .cmd_out(cmd_out));
    rtcl_cpu_model cpu_u (.clk(clk), .ale(ale), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe));
    always @(posedge clk) begin
        if (cnt_wr === 1'b1) begin
            cw_sel <= cnt_wsel;
            cw_dat <= cnt_wdata;
            cw_n <= cw_n + 1;
        end
    end
    // ****************************************
    // Helpers
    // ****************************************
    task automatic report_and_stop();
        if (errors == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            report_and_stop();
        end
    end
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("BAD %s exp %h got %h", nm, exp, got);
            errors++;
        end
    endtask : chk
    task automatic rdc(input logic [4:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic oe;
        cpu_u.bus_rd(a, d, oe);
        chk($sformatf("rd %h", a), exp, d);
        chk("data_oe", 8'h01, {7'h00, oe});
        // Bus must be let go once the strobe is gone
        chk("data_oe off", 8'h00, {7'h00, data_oe});
    endtask : rdc
    task automatic ichk(input logic exp);
        chk("int_oe", {7'h00, exp}, {7'h00, int_oe});
        chk("int_out", 8'h00, {7'h00, int_out});
    endtask : ichk
    // One-cycle increment pulse, then time for the flags to settle
    task automatic tick(input int b);
        cpu_u.step(1);
        per_tick[b] = 1'b1;
        cpu_u.step(1);
        per_tick = 6'h00;
        cpu_u.step(4);
    endtask : tick
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        rdc(ADR_EVT, EVT_RST);
        rdc(ADR_CMD, CMD_RST);
        rdc(5'h12, 8'h00);
        ichk(1'b0);
    endtask : t_reset
    task automatic t_snap();
        for (int i = 0; i < 8; i++) tm_v[i] = 8'h10 + 8'(i);
        rdc(ADR_TIME_LO, 8'h00);
        rdc(ADR_HUND, 8'h10);
        for (int i = 0; i < 8; i++) tm_v[i] = 8'h20 + 8'(i);
        for (int i = 1; i < 8; i++) rdc(5'(i), 8'h10 + 8'(i));
        rdc(ADR_HUND, 8'h20);
        tm_v[0] = 8'h33;
        rdc(ADR_HUND, 8'h33);
        rdc(ADR_TIME_HI, 8'h27);
    endtask : t_snap
    task automatic t_ram();
        for (int i = 0; i < 8; i++) cpu_u.bus_wr(ADR_ALM_LO + 5'(i), 8'h3c + 8'(i * 17));
        for (int i = 0; i < 8; i++) rdc(ADR_ALM_LO + 5'(i), 8'h3c + 8'(i * 17));
        cpu_u.bus_wr(5'h03, 8'h55);
        chk("cnt_wr count", 8'h01, 8'(cw_n));
        chk("cnt_wsel", 8'h03, {5'h00, cw_sel});
        chk("cnt_wdata", 8'h55, cw_dat);
    endtask : t_ram
    task automatic t_flags();
        // All periodic masks on, enable off: only the enable can hold the pin
        cpu_u.bus_wr(ADR_EVT, 8'h7e);
        for (int b = 0; b < NUM_PER; b++) tick(b);
        ichk(1'b0);
        rdc(ADR_EVT, 8'h7e);
        rdc(ADR_EVT, 8'h00);
    endtask : t_flags
    task automatic t_periodic();
        cpu_u.bus_wr(ADR_CMD, 8'h10);
        chk("cmd_out", 8'h10, cmd_out);
        rdc(ADR_CMD, 8'h10);
        cpu_u.bus_wr(ADR_EVT, 8'h08);
        ichk(1'b0);
        tick(0);
        ichk(1'b0);
        tick(2);
        ichk(1'b1);
        rdc(ADR_EVT, 8'h8a);
        ichk(1'b0);
        tick(3);
        ichk(1'b0);
        rdc(ADR_EVT, 8'h10);
    endtask : t_periodic
    task automatic t_alarm();
        cpu_u.bus_wr(ADR_ALM_LO, 8'h80);
        cpu_u.bus_wr(ADR_ALM_LO + 5'h01, 8'h12);
        for (int i = 2; i < 8; i++) cpu_u.bus_wr(ADR_ALM_LO + 5'(i), 8'h80);
        cpu_u.bus_wr(ADR_EVT, 8'h01);
        tm_v[1] = 8'h12;
        tm_v[0] = 8'h05;
        tick(0);
        ichk(1'b0);
        rdc(ADR_EVT, 8'h02);
        tm_v[0] = 8'h00;
        tick(0);
        ichk(1'b1);
        rdc(ADR_EVT, 8'h83);
        ichk(1'b0);
        cpu_u.step(20);
        rdc(ADR_EVT, 8'h00);
        tm_v[1] = 8'h13;
        tick(0);
        ichk(1'b0);
        tm_v[1] = 8'h12;
        cpu_u.bus_wr(ADR_EVT, 8'h00);
        rdc(ADR_EVT, 8'h02);
        tick(0);
        ichk(1'b0);
        rdc(ADR_EVT, 8'h02);
    endtask : t_alarm
    task automatic t_mid_reset();
        cpu_u.bus_wr(ADR_EVT, 8'h04);
        tick(1);
        ichk(1'b1);
        rst_n = 1'b0;
        cpu_u.step(2);
        rst_n = 1'b1;
        cpu_u.step(4);
        ichk(1'b0);
        chk("cmd_out", CMD_RST, cmd_out);
        rdc(ADR_EVT, EVT_RST);
        rdc(ADR_TIME_LO, 8'h00);
        rdc(ADR_ALM_LO + 5'h01, 8'h00);
        tick(1);
        ichk(1'b0);
    endtask : t_mid_reset
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        for (int i = 0; i < 8; i++) tm_v[i] = 8'h00;
        repeat (5) @(posedge clk);
        #1;
        rst_n = 1'b1;
        cpu_u.step(4);
        t_reset();
        t_snap();
        t_ram();
        t_flags();
        t_periodic();
        t_alarm();
        t_mid_reset();
        report_and_stop();
    end
endmodule : rtcl_top_tb
`default_nettype wire
